// ### capture_timer_pkg.sv
// Purpose: Shared constants for the two-channel 16-bit capture timer core.
// Assumes: Registers are word aligned; byte address is four times the index.
// Notes: Each printed register offset is kept here as a register index.

// ==========================================================================
// Package
// ==========================================================================
package capture_timer_pkg;

	// Bus geometry.
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BE_W = 4;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned CH_NUM = 2;

	// Register indices, one entry per channel (channel one first); the two interrupt registers have one index each.
	localparam logic [7:0] IDX_CNT_LOW [CH_NUM] = '{8'hd2, 8'he2};
	localparam logic [7:0] IDX_CNT_HIGH [CH_NUM] = '{8'hd3, 8'he3};
	localparam logic [7:0] IDX_PER_LOW [CH_NUM] = '{8'hd4, 8'he4};
	localparam logic [7:0] IDX_PER_HIGH [CH_NUM] = '{8'hd5, 8'he5};
	localparam logic [7:0] IDX_CTRL [CH_NUM] = '{8'hd6, 8'he6};
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;

	// Control register layout.
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_CLEAR_BIT = 2;
	localparam int unsigned CTRL_RUN_BIT = 3;
	localparam int unsigned CTRL_W = 4;

	// Values of the timer_mode_select field.
	localparam logic [1:0] MODE_AUTO_RELOAD = 2'h0;
	localparam logic [1:0] MODE_CAPTURE_RISE = 2'h1;
	localparam logic [1:0] MODE_CAPTURE_FALL = 2'h2;
	localparam logic [1:0] MODE_CAPTURE_ANY = 2'h3;

	// Reset values and counter limits.
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] PER_RESET = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam logic [CH_NUM-1:0] IRQ_RESET = 2'h0;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

endpackage

// ### capture_timer_counter.sv
// Purpose: Counter core of two 16-bit timer channels behind an Avalon-MM
//          slave, with sticky per-channel interrupt flags and a mask.
// Assumes: One clock, ref_clk at 125 MHz; all bus inputs on that clock.
// Notes: Counters advance once per ref_clk cycle while their run bit is set and their clear bit is not.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps

// ==========================================================================
// Top module
// ==========================================================================
module capture_timer_counter
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [capture_timer_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [capture_timer_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [capture_timer_pkg::BE_W-1:0] avs_byteenable,
	output logic [capture_timer_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq
);
	import capture_timer_pkg::*;

	// ======================================================================
	// Functions
	// ======================================================================

	// One count step. The top bit flags the wrap back to zero. In any
	// capture mode the wrap point is 65535; in auto-reload it is N minus
	// one, so N of zero also gives a period of 65536 counts.
	function automatic logic [16:0] count_step
	(
		input logic [15:0] cnt,
		input logic [15:0] period,
		input logic [1:0] mode
	);
		logic [15:0] top;
		if (mode == MODE_AUTO_RELOAD)
		begin
			top = period - CNT_ONE;
		end
		else
		begin
			top = CNT_MAX;
		end
		if (cnt == top)
		begin
			count_step = {1'b1, CNT_RESET};
		end
		else
		begin
			count_step = {1'b0, cnt + CNT_ONE};
		end
	endfunction

	// Write hit on one register index, low byte lane enabled.
	function automatic logic wr_hit
	(
		input logic [7:0] idx,
		input logic [7:0] target,
		input logic strobe
	);
		wr_hit = strobe && (idx == target);
	endfunction

	// ======================================================================
	// State
	// ======================================================================
	logic [15:0] cnt_reg [CH_NUM];
	logic [15:0] cnt_next [CH_NUM];
	logic [15:0] period_reg [CH_NUM];
	logic [15:0] period_next [CH_NUM];
	logic [CTRL_W-1:0] ctrl_reg [CH_NUM];
	logic [CTRL_W-1:0] ctrl_next [CH_NUM];
	logic [CH_NUM-1:0] status_reg;
	logic [CH_NUM-1:0] status_next;
	logic [CH_NUM-1:0] mask_reg;
	logic [CH_NUM-1:0] mask_next;
	logic wait_reg;
	logic wait_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic irq_reg;
	logic irq_next;

	logic [7:0] reg_idx;
	logic wr_strobe;
	logic [16:0] step [CH_NUM];
	logic [CH_NUM-1:0] wrap_event;
	logic [CH_NUM-1:0] w1c;
	logic [DATA_W-1:0] rd_mux;

	// Byte address to register index; lower two bits select no register.
	assign reg_idx = avs_address[IDX_LSB +: 8];

	// A write takes effect only at the edge where the master sees
	// waitrequest low, and only when the byte lane holding data is enabled.
	assign wr_strobe = avs_write && !wait_reg && avs_byteenable[0];

	// ======================================================================
	// Counters and per-channel control
	// ======================================================================

	// Counting, clearing and control writes. Counter registers have no
	// write path at all, so a write to them is silently dropped.
	always_comb
	begin
		for (int ch = 0; ch < CH_NUM; ch++)
		begin
			cnt_next[ch] = cnt_reg[ch];
			period_next[ch] = period_reg[ch];
			ctrl_next[ch] = ctrl_reg[ch];
			wrap_event[ch] = 1'b0;
			step[ch] = count_step(cnt_reg[ch], period_reg[ch],
				ctrl_reg[ch][CTRL_MODE_LSB +: 2]);
			if (ctrl_reg[ch][CTRL_CLEAR_BIT])
			begin
				cnt_next[ch] = CNT_RESET;
			end
			else if (ctrl_reg[ch][CTRL_RUN_BIT])
			begin
				cnt_next[ch] = step[ch][15:0];
				wrap_event[ch] = step[ch][16];
			end
			if (wr_hit(reg_idx, IDX_PER_LOW[ch], wr_strobe))
			begin
				period_next[ch][7:0] = avs_writedata[7:0];
			end
			if (wr_hit(reg_idx, IDX_PER_HIGH[ch], wr_strobe))
			begin
				period_next[ch][15:8] = avs_writedata[7:0];
			end
			if (wr_hit(reg_idx, IDX_CTRL[ch], wr_strobe))
			begin
				ctrl_next[ch] = avs_writedata[CTRL_W-1:0];
			end
		end
	end

	// Register the counter state.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int ch = 0; ch < CH_NUM; ch++)
			begin
				cnt_reg[ch] <= CNT_RESET;
				period_reg[ch] <= PER_RESET;
				ctrl_reg[ch] <= CTRL_RESET;
			end
		end
		else
		begin
			for (int ch = 0; ch < CH_NUM; ch++)
			begin
				cnt_reg[ch] <= cnt_next[ch];
				period_reg[ch] <= period_next[ch];
				ctrl_reg[ch] <= ctrl_next[ch];
			end
		end
	end

	// ======================================================================
	// Interrupt flags
	// ======================================================================

	// Sticky timer_irq_flag bits, cleared by writing one. The set is
	// applied after the clear so an event in the clearing cycle survives.
	always_comb
	begin
		w1c = '0;
		mask_next = mask_reg;
		if (wr_hit(reg_idx, IDX_IRQ_STATUS, wr_strobe))
		begin
			w1c = avs_writedata[CH_NUM-1:0];
		end
		if (wr_hit(reg_idx, IDX_IRQ_MASK, wr_strobe))
		begin
			mask_next = avs_writedata[CH_NUM-1:0];
		end
		status_next = (status_reg & ~w1c) | wrap_event;
		irq_next = |(status_next & mask_next);
	end

	// Register the interrupt state.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_reg <= IRQ_RESET;
			mask_reg <= IRQ_RESET;
			irq_reg <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			irq_reg <= irq_next;
		end
	end

	// ======================================================================
	// Avalon-MM slave
	// ======================================================================

	// Read multiplexer. Narrow registers sit in the low bits; unmapped
	// indices and unused bits read as zero. The high byte is not latched
	// on a low-byte read, so software reading both halves of a running
	// counter may see a carry between the two accesses.
	always_comb
	begin
		rd_mux = RDATA_RESET;
		for (int ch = 0; ch < CH_NUM; ch++)
		begin
			if (reg_idx == IDX_CNT_LOW[ch])
			begin
				rd_mux[7:0] = cnt_reg[ch][7:0];
			end
			if (reg_idx == IDX_CNT_HIGH[ch])
			begin
				rd_mux[7:0] = cnt_reg[ch][15:8];
			end
			if (reg_idx == IDX_PER_LOW[ch])
			begin
				rd_mux[7:0] = period_reg[ch][7:0];
			end
			if (reg_idx == IDX_PER_HIGH[ch])
			begin
				rd_mux[7:0] = period_reg[ch][15:8];
			end
			if (reg_idx == IDX_CTRL[ch])
			begin
				rd_mux[CTRL_W-1:0] = ctrl_reg[ch];
			end
		end
		if (reg_idx == IDX_IRQ_STATUS)
		begin
			rd_mux[CH_NUM-1:0] = status_reg;
		end
		if (reg_idx == IDX_IRQ_MASK)
		begin
			rd_mux[CH_NUM-1:0] = mask_reg;
		end
	end

	// Waitrequest idles high and drops for exactly one cycle per access.
	// That costs one wait state but keeps every bus output on a flop.
	always_comb
	begin
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		if ((avs_read || avs_write) && wait_reg)
		begin
			wait_next = 1'b0;
			if (avs_read)
			begin
				rdata_next = rd_mux;
			end
		end
	end

	// Register the bus answer.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_reg <= 1'b1;
			rdata_reg <= RDATA_RESET;
		end
		else
		begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// Outputs come straight from flops.
	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign irq = irq_reg;

endmodule

// ### capture_timer_monitor.sv
// Purpose: Port checks of the timer core bus and interrupt.
// Assumes: Only the top-level ports are visible.
// Notes: Counter values are judged by the bench.
`timescale 1ns/10ps
// ==========================================================================
// Checker
// ==========================================================================
module capture_timer_monitor
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq
);
	// Short names keep each property on one line.
	wire logic req = avs_read | avs_write;
	wire logic busy = avs_waitrequest;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Each request is answered once, exactly one cycle after it is taken.
	a_ack_next: assert property (req && busy |=> !busy)
		else $error("ack missing");
	a_ack_single: assert property (!busy |=> busy)
		else $error("ack too long");
	a_ack_cause: assert property (!busy |-> $past(req) && $past(busy))
		else $error("ack without request");
	a_idle_wait: assert property (!req |=> busy)
		else $error("ack while idle");
	// Read data may only move with an answer.
	a_data_hold: assert property (busy |-> $stable(avs_readdata))
		else $error("read data moved");
	a_data_upper: assert property (avs_read && busy |=> avs_readdata[31:8] == '0)
		else $error("upper read bits set");
	a_unmapped_zero: assert property (avs_read && busy && avs_address == '0
		|=> avs_readdata == '0)
		else $error("unmapped read not zero");
	// Flags are sticky, so irq may only drop after a bus write.
	a_irq_fall: assert property ($fell(irq) |-> $past(avs_write) ||
		$past(avs_write, 2) || $past(avs_write, 3))
		else $error("irq dropped without write");
	c_irq: cover property ($rose(irq));
	c_read: cover property (avs_read && !busy);
	c_write: cover property (avs_write && !busy);
endmodule
bind capture_timer_counter capture_timer_monitor capture_timer_monitor_inst
(
	.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .irq
);

// ### capture_timer_counter_test.sv
// Purpose: Self-checking bench for the timer core.
// Assumes: Each access is answered one cycle after it is taken.
// Notes: Event periods are measured in ref_clk cycles between irq rises.
`timescale 1ns/10ps
// ==========================================================================
// Bench
// ==========================================================================
module capture_timer_counter_test;
	import capture_timer_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic [31:0] rd_val;
	logic [7:0] regs [10] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'he2,
		8'he6, 8'hf0, 8'hf1, 8'h00};
	logic [15:0] per;
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	int t0;
	int t1;
	int t2;
	capture_timer_counter capture_timer_counter_inst
	(
		.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq
	);
	// Clock and a cycle count used for timing comparisons.
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;
	// One bus access; the trailing edge keeps strobes from toggling twice.
	task automatic access(input logic [7:0] idx, input logic wr,
		input logic [7:0] d);
		avs_address <= {idx, 2'b00};
		avs_writedata <= 32'(d);
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd_val = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic cmp(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Irq rises in the same cycle as its flag; two edges pass before sampling.
	task automatic wait_irq(output int t);
		repeat (2) @(posedge ref_clk);
		do @(posedge ref_clk); while (irq !== 1'b1);
		t = cyc;
	endtask
	task automatic results;
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Cuts a hang short well past the longest expected run.
	initial
	begin
		#800000;
		fail_count++;
		results();
	end
	// Main sequence.
	initial
	begin
		void'($urandom(32'h6597));
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		foreach (regs[i])
		begin
			access(regs[i], 1'b0, 8'h00);
			cmp("reset", '0, rd_val);
		end
		access(8'hd2, 1'b1, 8'h80 | 8'($urandom));
		access(8'hd2, 1'b0, 8'h00);
		cmp("ro_low", '0, rd_val);
		per = 16'(16 + $urandom % 32);
		access(IDX_IRQ_MASK, 1'b1, 8'h03);
		// A write with its data lane disabled must leave the mask alone.
		avs_byteenable <= 4'h0;
		access(IDX_IRQ_MASK, 1'b1, 8'h00);
		avs_byteenable <= 4'h1;
		access(IDX_IRQ_MASK, 1'b0, 8'h00);
		cmp("mask_lane", 32'h0000_0003, rd_val);
		access(8'hd4, 1'b1, per[7:0]);
		access(8'he4, 1'b1, per[7:0]);
		access(8'hd6, 1'b1, 8'h08);
		t0 = cyc;
		wait_irq(t1);
		cmp("first_match", 32'(per), 32'(t1 - t0));
		repeat (3)
		begin
			access(8'hd2, 1'b0, 8'h00);
			cmp("in_range", 1, rd_val < 32'(per));
			access(IDX_IRQ_STATUS, 1'b1, 8'h01);
			wait_irq(t2);
			cmp("period", 32'(per), 32'(t2 - t1));
			t1 = t2;
		end
		access(8'hd6, 1'b1, 8'h0c);
		access(8'hd2, 1'b0, 8'h00);
		cmp("clear", '0, rd_val);
		access(8'hd6, 1'b1, 8'h08);
		access(IDX_IRQ_MASK, 1'b1, 8'h02);
		// Capture mode ignores the period, so the event needs 65536 counts.
		access(8'he6, 1'b1, 8'h08 | 8'(1 + $urandom % 3));
		t0 = cyc;
		wait_irq(t1);
		cmp("overflow", 32'(65536), 32'(t1 - t0));
		// The wrap landed two edges before this read, so one count follows.
		access(8'he2, 1'b0, 8'h00);
		cmp("keeps_running", 32'h0000_0001, rd_val);
		access(IDX_IRQ_STATUS, 1'b0, 8'h00);
		cmp("status", 32'h0000_0003, rd_val);
		access(IDX_IRQ_STATUS, 1'b1, 8'h02);
		access(IDX_IRQ_STATUS, 1'b0, 8'h00);
		cmp("w1c", '0, rd_val & 32'h0000_0002);
		results();
	end
endmodule
